// *** common/listen_seq_regs.svh ***
`ifndef LISTEN_SEQ_REGS_SVH
`define LISTEN_SEQ_REGS_SVH
// Notes on behaviour
// - Idle phase runs on RC oscillator only
// - Wanted signal keeps receiver on, else off
// - Packet reception raises host interrupt
// - Exit on preamble, sync or payload done
// - Preamble stop leaves radio receiving
// - Window every idle plus rx timer period
// - No preamble by window end: back to sleep
// - Wake-on-preamble transition field settings
// - Preamble found routable to pin 4, code 11

// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL       8'h00
`define OFS_IDLE_TMR   8'h04
`define OFS_RX_TMR     8'h08
`define OFS_STATE      8'h0c
`define OFS_IRQ_STAT   8'h10
`define OFS_IRQ_MASK   8'h14
`define OFS_PIN_MAP    8'h18

// ****************************************
// Control fields
// ****************************************
`define CTRL_START     0
`define CTRL_STOP      1
`define CTRL_ROUTE     2
`define CTRL_IDLE_SEL  3
`define CTRL_START_TR  4
`define CTRL_LP_CHOICE 6
`define CTRL_IDLE_EXIT 7
`define CTRL_RX_EXIT   8
`define CTRL_RST       11'h6c8
`define CTRL_RW_MASK   11'h7fc

// ****************************************
// Transition codes
// ****************************************
`define START_TO_LP    2'h0
`define RX_EXIT_PREAM  3'h6
`define RX_EXIT_SYNC   3'h5
`define RX_EXIT_PAYLD  3'h4
`define PIN_CODE_PREAM 2'h3

// ****************************************
// Interrupt bits and reset values
// ****************************************
`define IRQ_PREAM      0
`define IRQ_SYNC       1
`define IRQ_PACKET     2
`define IRQ_TIMEOUT    3
`define IRQ_STOPPED    4
`define IRQ_W          5
`define IDLE_TMR_RST   16'h0010
`define RX_TMR_RST     16'h0002
`define PIN_MAP_RST    10'h331

// ****************************************
// Timer tick
// ****************************************
`define CLK_NS         100
`define TICK_NS        64000
`define TICK_CYC       (`TICK_NS / `CLK_NS)
`endif

// *** common/listen_seq_pkg.sv ***
package listen_seq_pkg;
  // Sequencer states; HELD is sequencer off with receiver kept on
  typedef enum logic [2:0] {
    ST_OFF,
    ST_LOWPOW,
    ST_IDLE,
    ST_RX,
    ST_HELD
  } seq_state_e;
endpackage

// *** design/listen_mode_sequencer.sv ***
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "listen_seq_regs.svh"
module listen_mode_sequencer #(
  parameter int TIMER_W = 16
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        preamble_found_in,
  input  wire logic        sync_match_in,
  input  wire logic        payload_done_in,
  input  wire logic        checksum_good_in,
  input  wire logic        queue_threshold_in,
  input  wire logic        queue_drained_in,
  output logic             sleep_out,
  output logic             standby_out,
  output logic             rx_on_out,
  output logic             rc_only_out,
  output logic             seq_running_out,
  output logic [4:0]       event_pin_out,
  output logic             irq_out
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (TIMER_W < 2 || TIMER_W > 24) begin : g_chk
    $error("TIMER_W must lie between 2 and 24");
  end
  localparam int TICK_W = $clog2(`TICK_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(`TICK_CYC - 1);
  // ****************************************
  // Register state
  // ****************************************
  logic [10:0]          ctrl;
  logic [TIMER_W-1:0]   idle_wait_timer;
  logic [TIMER_W-1:0]   rx_window_timer;
  logic [`IRQ_W-1:0]    irq_stat;
  logic [`IRQ_W-1:0]    irq_mask;
  logic [9:0]           pin_map;
  logic [10:0]          next_ctrl;
  logic [TIMER_W-1:0]   next_idle_wait;
  logic [TIMER_W-1:0]   next_rx_window;
  logic [`IRQ_W-1:0]    next_irq_stat;
  logic [`IRQ_W-1:0]    next_irq_mask;
  logic [9:0]           next_pin_map;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic                 next_irq;

  // ****************************************
  // Sequencer state
  // ****************************************
  listen_seq_pkg::seq_state_e state;
  listen_seq_pkg::seq_state_e next_state;
  logic [TICK_W-1:0]    div;
  logic [TICK_W-1:0]    next_div;
  logic [TIMER_W-1:0]   tmr;
  logic [TIMER_W-1:0]   next_tmr;
  logic [`IRQ_W-1:0]    irq_set;
  logic                 next_sleep;
  logic                 next_standby;
  logic                 next_rx_on;
  logic                 next_running;
  logic [4:0]           next_pins;

  // ****************************************
  // Bus decode
  // ****************************************
  logic                 access;
  logic                 wr_en;
  logic                 start_req;
  logic                 stop_req;
  logic                 tick;
  logic [TIMER_W:0]     tmr_inc;
  logic                 idle_timer_event;
  logic                 window_end;
  logic                 exit_hit;
  // Access phase first cycle; answer follows one cycle later
  assign access    = psel_in && penable_in && !pready_out;
  // Write lands only at the edge where pready is seen high
  assign wr_en     = psel_in && penable_in && pready_out && pwrite_in;
  assign start_req = wr_en && (paddr_in == `OFS_CTRL) && pwdata_in[`CTRL_START];
  assign stop_req  = wr_en && (paddr_in == `OFS_CTRL) && pwdata_in[`CTRL_STOP];

  // ****************************************
  // Register next values
  // ****************************************
  always_comb begin
    next_ctrl      = ctrl;
    next_idle_wait = idle_wait_timer;
    next_rx_window = rx_window_timer;
    next_irq_mask  = irq_mask;
    next_pin_map   = pin_map;
    next_pready    = access;
    next_pslverr   = 1'b0;
    next_prdata    = 32'h0000_0000;
    // Set wins over a same-cycle write-one clear
    next_irq_stat  = irq_stat | irq_set;
    if (wr_en) begin
      case (paddr_in)
        `OFS_CTRL: begin
          next_ctrl = pwdata_in[10:0] & `CTRL_RW_MASK;
        end
        `OFS_IDLE_TMR: begin
          next_idle_wait = pwdata_in[TIMER_W-1:0];
        end
        `OFS_RX_TMR: begin
          next_rx_window = pwdata_in[TIMER_W-1:0];
        end
        `OFS_IRQ_STAT: begin
          next_irq_stat = (irq_stat & ~pwdata_in[`IRQ_W-1:0]) | irq_set;
        end
        `OFS_IRQ_MASK: begin
          next_irq_mask = pwdata_in[`IRQ_W-1:0];
        end
        `OFS_PIN_MAP: begin
          next_pin_map = pwdata_in[9:0];
        end
        default: ;
      endcase
    end
    if (access) begin
      case (paddr_in)
        `OFS_CTRL:     next_prdata = {21'h0, ctrl};
        `OFS_IDLE_TMR: next_prdata = 32'(idle_wait_timer);
        `OFS_RX_TMR:   next_prdata = 32'(rx_window_timer);
        `OFS_STATE:    next_prdata = {25'h0, rc_only_out, rx_on_out, standby_out,
                                      sleep_out, 3'(state)};
        `OFS_IRQ_STAT: next_prdata = 32'(irq_stat);
        `OFS_IRQ_MASK: next_prdata = 32'(irq_mask);
        `OFS_PIN_MAP:  next_prdata = {22'h0, pin_map};
        default:       next_pslverr = 1'b1; // Unmapped: error, data zero
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // Register flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl            <= `CTRL_RST;
      idle_wait_timer <= TIMER_W'(`IDLE_TMR_RST);
      rx_window_timer <= TIMER_W'(`RX_TMR_RST);
      irq_stat        <= '0;
      irq_mask        <= '0;
      pin_map         <= `PIN_MAP_RST;
      prdata_out      <= 32'h0000_0000;
      pready_out      <= 1'b0;
      pslverr_out     <= 1'b0;
      irq_out         <= 1'b0;
    end else begin
      ctrl            <= next_ctrl;
      idle_wait_timer <= next_idle_wait;
      rx_window_timer <= next_rx_window;
      irq_stat        <= next_irq_stat;
      irq_mask        <= next_irq_mask;
      pin_map         <= next_pin_map;
      prdata_out      <= next_prdata;
      pready_out      <= next_pready;
      pslverr_out     <= next_pslverr;
      irq_out         <= next_irq;
    end
  end

  // ****************************************
  // Timebase and timer compare
  // ****************************************
  // Tick divider only runs while a timer is live, so it stops when off
  assign tick    = (div == TICK_LAST);
  assign tmr_inc = {1'b0, tmr} + {{TIMER_W{1'b0}}, 1'b1};
  // A timer of zero behaves as one tick, never as a stall
  assign idle_timer_event = (state == listen_seq_pkg::ST_IDLE) && tick &&
                            (tmr_inc >= {1'b0, idle_wait_timer});
  assign window_end = (state == listen_seq_pkg::ST_RX) && tick &&
                      (tmr_inc >= {1'b0, rx_window_timer});

  // Selected receive exit event
  always_comb begin
    case (ctrl[`CTRL_RX_EXIT +: 3])
      `RX_EXIT_PREAM: exit_hit = preamble_found_in;
      `RX_EXIT_SYNC:  exit_hit = sync_match_in;
      `RX_EXIT_PAYLD: exit_hit = payload_done_in;
      default:        exit_hit = 1'b0;
    endcase
  end

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    next_state = state;
    next_div   = div;
    next_tmr   = tmr;
    irq_set    = '0;
    case (state)
      listen_seq_pkg::ST_OFF,
      listen_seq_pkg::ST_HELD: begin
        // Nothing moves until the host writes start, or stop to leave HELD
        next_div = '0;
        next_tmr = '0;
        if (start_req) begin
          if (next_ctrl[`CTRL_START_TR +: 2] == `START_TO_LP) begin // Field of this write
            next_state = listen_seq_pkg::ST_LOWPOW;
          end else begin
            next_state = listen_seq_pkg::ST_RX;
          end
        end else if (stop_req) begin
          // Host picks another mode: release the receiver
          next_state = listen_seq_pkg::ST_OFF;
        end
      end
      listen_seq_pkg::ST_LOWPOW: begin
        next_div = '0;
        next_tmr = '0;
        if (ctrl[`CTRL_LP_CHOICE]) begin
          next_state = listen_seq_pkg::ST_IDLE;
        end else begin
          next_state = listen_seq_pkg::ST_OFF;
          irq_set[`IRQ_STOPPED] = 1'b1;
        end
      end
      listen_seq_pkg::ST_IDLE: begin
        next_div = tick ? '0 : div + TICK_W'(1);
        next_tmr = tick ? tmr_inc[TIMER_W-1:0] : tmr;
        if (idle_timer_event) begin
          next_div = '0;
          next_tmr = '0;
          if (ctrl[`CTRL_IDLE_EXIT]) begin
            next_state = listen_seq_pkg::ST_RX;
          end else begin
            next_state = listen_seq_pkg::ST_OFF;
            irq_set[`IRQ_STOPPED] = 1'b1;
          end
        end
      end
      listen_seq_pkg::ST_RX: begin
        next_div = tick ? '0 : div + TICK_W'(1);
        next_tmr = tick ? tmr_inc[TIMER_W-1:0] : tmr;
        if (exit_hit) begin
          // Wanted signal: keep receiving, stop sequencing
          next_state = listen_seq_pkg::ST_HELD;
          irq_set[`IRQ_STOPPED] = 1'b1;
        end else if (window_end) begin
          // No wanted signal: back to low power, receiver off
          next_state = listen_seq_pkg::ST_LOWPOW;
          irq_set[`IRQ_TIMEOUT] = 1'b1;
        end
      end
      default: begin
        next_state = listen_seq_pkg::ST_OFF;
      end
    endcase
    // Host stop overrides any running state
    if (stop_req && state != listen_seq_pkg::ST_OFF &&
        state != listen_seq_pkg::ST_HELD) begin
      next_state = listen_seq_pkg::ST_OFF;
      next_div   = '0;
      next_tmr   = '0;
    end
    // Events only count while the receiver listens
    if (state == listen_seq_pkg::ST_RX || state == listen_seq_pkg::ST_HELD) begin
      irq_set[`IRQ_PREAM]  = preamble_found_in;
      irq_set[`IRQ_SYNC]   = sync_match_in;
      irq_set[`IRQ_PACKET] = payload_done_in;
    end
  end

  // ****************************************
  // Radio mode outputs
  // ****************************************
  always_comb begin
    next_sleep   = (next_state == listen_seq_pkg::ST_IDLE) &&
                   ctrl[`CTRL_IDLE_SEL];
    next_rx_on   = (next_state == listen_seq_pkg::ST_RX) ||
                   (next_state == listen_seq_pkg::ST_HELD);
    next_standby = !next_sleep && !next_rx_on;
    next_running = (next_state != listen_seq_pkg::ST_OFF) &&
                   (next_state != listen_seq_pkg::ST_HELD);
  end

  // ****************************************
  // Event pin mapping
  // ****************************************
  // Per pin a two-bit source code; unlisted codes drive low
  function automatic logic pin_src(input int pin, input logic [1:0] code,
                                   input logic route);
    logic res;
    res = 1'b0;
    case (pin)
      0: res = (code == 2'h0) ? payload_done_in :
               (code == 2'h1) ? checksum_good_in : 1'b0;
      1: res = (code == 2'h0) ? queue_threshold_in : 1'b0;
      2: res = (code == 2'h3) ? sync_match_in : 1'b0;
      3: res = (code == 2'h0) ? queue_drained_in : 1'b0;
      4: res = (code == `PIN_CODE_PREAM) && route && preamble_found_in;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  for (genvar p = 0; p < 5; p++) begin : g_pin
    // Preamble needs both the pin code and the route bit
    assign next_pins[p] = pin_src(p, pin_map[2*p +: 2], ctrl[`CTRL_ROUTE]);
  end

  // Sequencer flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state           <= listen_seq_pkg::ST_OFF;
      div             <= '0;
      tmr             <= '0;
      sleep_out       <= 1'b0;
      standby_out     <= 1'b1;
      rx_on_out       <= 1'b0;
      rc_only_out     <= 1'b0;
      seq_running_out <= 1'b0;
      event_pin_out   <= 5'h00;
    end else begin
      state           <= next_state;
      div             <= next_div;
      tmr             <= next_tmr;
      sleep_out       <= next_sleep;
      standby_out     <= next_standby;
      rx_on_out       <= next_rx_on;
      rc_only_out     <= next_sleep;
      seq_running_out <= next_running;
      event_pin_out   <= next_pins;
    end
  end
endmodule

// *** verif/listen_seq_properties.sv ***
`timescale 1ns/1ps
module listen_seq_properties (
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic       preamble_found_in,
  input wire logic       pready_out,
  input wire logic       sleep_out,
  input wire logic       standby_out,
  input wire logic       rx_on_out,
  input wire logic       rc_only_out,
  input wire logic       seq_running_out,
  input wire logic [4:0] event_pin_out
);
  // ************
  // Phase length counters
  // ************
  localparam int TICK = 640;
  int idle_cnt;
  int win_cnt;
  int next_idle_cnt;
  int next_win_cnt;
  // Lengths are only judged at phase end, so a stop mid-phase is harmless
  always_comb begin
    next_idle_cnt = sleep_out ? idle_cnt + 1 : 0;
    next_win_cnt  = (rx_on_out && seq_running_out) ? win_cnt + 1 : 0;
  end
  // Counter registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idle_cnt <= 0;
      win_cnt  <= 0;
    end else begin
      idle_cnt <= next_idle_cnt;
      win_cnt  <= next_win_cnt;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ************
  // Properties
  // ************
  AST_RC_ONLY: assert property (rc_only_out == sleep_out)
    else $error("rc only flag differs from sleep");
  AST_ONE_MODE: assert property ($onehot({sleep_out, standby_out, rx_on_out}))
    else $error("power modes not exclusive");
  AST_BACK_TO_SLEEP: assert property ($fell(rx_on_out) && seq_running_out |=> sleep_out)
    else $error("window end did not return to sleep");
  AST_IDLE_LEN: assert property ($fell(sleep_out) && rx_on_out |->
    idle_cnt % TICK == 0 && idle_cnt != 0) else $error("idle phase not whole ticks");
  AST_WIN_LEN: assert property ($fell(rx_on_out) && seq_running_out |->
    win_cnt % TICK == 0 && win_cnt != 0) else $error("window not whole ticks");
  AST_HELD_STAYS: assert property (rx_on_out && !seq_running_out && !psel_in |=> rx_on_out)
    else $error("held receive dropped without host");
  AST_OFF_STILL: assert property (!seq_running_out && !psel_in |=> !seq_running_out)
    else $error("stopped sequencer restarted alone");
  AST_PIN4: assert property (event_pin_out[4] |-> $past(preamble_found_in))
    else $error("pin 4 high without preamble");
  AST_APB_WAIT: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("bus answer late");
  AST_APB_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
endmodule

bind listen_mode_sequencer listen_seq_properties i_props (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
  .preamble_found_in(preamble_found_in), .pready_out(pready_out), .sleep_out(sleep_out),
  .standby_out(standby_out), .rx_on_out(rx_on_out), .rc_only_out(rc_only_out),
  .seq_running_out(seq_running_out), .event_pin_out(event_pin_out)
);

// *** verif/peer_radio_model.sv ***
`timescale 1ns/1ps
module peer_radio_model #(
  parameter int PREAMBLE_CYC = 2560
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic send_in,
  input  wire logic rx_on_in,
  output logic      preamble_found_out
);
  // ************
  // Transmitting peer and preamble detector
  // ************
  int left;
  // Preamble spans idle plus two windows, so one window must overlap it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      left <= 0;
    end else if (send_in) begin
      left <= PREAMBLE_CYC;
    end else if (left != 0) begin
      left <= left - 1;
    end
  end
  // Detector only sees it while the receiver listens
  assign preamble_found_out = (left != 0) && rx_on_in;
endmodule

// *** verif/listen_mode_sequencer_test.sv ***
`timescale 1ns/1ps
module listen_mode_sequencer_test;
  // ************
  // Bench signals and instances
  // ************
  logic        clk_in   = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [2:0]  evt      = 3'h0;
  logic [2:0]  side_evt = 3'h0;
  logic        send     = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic        pready, pslverr, slverr, sleep, standby, rx_on, rc_only, running, irq, peer;
  logic [4:0]  pins;
  logic [31:0] rst_val [7] = '{32'h6c8, 32'h10, 32'h2, 32'h10, 32'h0, 32'h0, 32'h331};
  int          err_count   = 0;
  int          checks_done = 0;
  int          n;

  listen_mode_sequencer i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .preamble_found_in(peer | evt[0]),
    .sync_match_in(evt[1]), .payload_done_in(evt[2]), .checksum_good_in(side_evt[0]),
    .queue_threshold_in(side_evt[1]), .queue_drained_in(side_evt[2]), .sleep_out(sleep),
    .standby_out(standby), .rx_on_out(rx_on), .rc_only_out(rc_only),
    .seq_running_out(running), .event_pin_out(pins), .irq_out(irq)
  );
  peer_radio_model i_peer (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .send_in(send), .rx_on_in(rx_on),
    .preamble_found_out(peer)
  );

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  // ************
  // Tasks
  // ************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One bus transfer; holds everything until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int w;
    w = 0;
    @(posedge clk_in);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    while (pready !== 1'b1 && w < 20) begin
      w++;
      @(posedge clk_in);
    end
    if (w == 20) err_count++;
    rdata   = prdata;
    slverr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, rdata);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Bounded wait for the receiver to reach a level, counting cycles
  task automatic wait_rx(input logic v);
    n = 0;
    while (rx_on !== v && n < 3000) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 3000) err_count++;
  endtask
  task automatic pulse(input logic [2:0] e);
    evt <= e;
    @(posedge clk_in);
    evt <= 3'h0;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic final_report();
    $display("Checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ************
  // Tests
  // ************
  initial begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), rst_val[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, slverr});
    side_evt <= 3'h7;
    repeat (2) @(posedge clk_in);
    chk("pins 3 to 0", 32'hb, {28'h0, pins[3:0]});
    side_evt <= 3'h0;
    // Idle wait longer than the one-tick window
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h1);
    wr(8'h14, 32'h1f);
    wr(8'h00, 32'h6cd);
    repeat (2) @(posedge clk_in);
    chk("idle modes", 32'hc, {28'h0, sleep, rc_only, rx_on, standby});
    wait_rx(1'b1);
    chk("idle cycles", 32'd1280, n);
    wait_rx(1'b0);
    chk("window cycles", 32'd640, n);
    @(posedge clk_in);
    chk("sleep again", 32'h1, {31'h0, sleep});
    rd(8'h10, 32'h8);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(8'h10, 32'h8);
    rd(8'h10, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h6ce);
    // Each exit code ends only on its own event
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {21'h0, 3'(6 - i), 8'hcd});
      wait_rx(1'b1);
      pulse(3'h1 << ((i + 1) % 3));
      chk("running after other event", 32'h1, {31'h0, running});
      pulse(3'h1 << i);
      chk("held after exit event", 32'h1, {30'h0, running, rx_on});
      wr(8'h00, 32'h6ce);
    end
    // Start field 01 skips low power and opens a window at once
    wr(8'h00, 32'h6dd);
    wait_rx(1'b1);
    chk("direct receive", 32'd1, n);
    wr(8'h00, 32'h6ce);
    // Peer preamble wakes the radio and stops the sequencer
    wr(8'h10, 32'h1f);
    wr(8'h00, 32'h6cd);
    send <= 1'b1;
    @(posedge clk_in);
    send <= 1'b0;
    wait_rx(1'b1);
    repeat (2) @(posedge clk_in);
    chk("held receive", 32'h1, {30'h0, running, rx_on});
    chk("pin 4", 32'h1, {31'h0, pins[4]});
    rd(8'h10, 32'h11);
    chk("irq preamble", 32'h1, {31'h0, irq});
    wr(8'h14, 32'h0);
    repeat (2) @(posedge clk_in);
    chk("irq masked", 32'h0, {31'h0, irq});
    repeat (700) @(posedge clk_in);
    chk("still held", 32'h1, {30'h0, running, rx_on});
    wr(8'h00, 32'h6ce);
    repeat (2) @(posedge clk_in);
    chk("off after stop", 32'h1, {29'h0, running, rx_on, standby});
    final_report();
  end

  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    final_report();
  end
endmodule
